// ### pkg/acl_action_defines.vh
// constants for the acl action-processing block
`ifndef ACL_ACTION_DEFINES_VH
`define ACL_ACTION_DEFINES_VH
// ************************************************************
// direct register addresses
// ************************************************************
`define ACL_REG_IND_CTRL 8'h6e
`define ACL_REG_IND_ADDR 8'h6f
`define ACL_REG_IND_DATA 8'ha0
`define ACL_TABLE_SEL 3'h2
// ************************************************************
// entry byte offsets and fields
// ************************************************************
`define ACL_OFS_REMARK 8'h0a
`define ACL_OFS_FORWARD 8'h0b
`define ACL_RESET_BYTE 8'h00
`define ACL_REMARK_EN_BIT 2
`define ACL_MAP_OR 2'h1
`define ACL_MAP_AND 2'h2
`define ACL_MAP_REPLACE 2'h3
`define ACL_MATCH_COUNT 2'h1
`define ACL_ENABLE_COUNT 2'h0
`define ACL_UNIT_BIT 4
`define ACL_CMODE_BIT 3
// ************************************************************
// timing
// ************************************************************
`define ACL_CLK_MHZ 50
`define ACL_US_PER_MS 1000
`define ACL_CYC_PER_US (`ACL_CLK_MHZ)
// last divider states, sized to the prescaler registers: 50 - 1 and 1000 - 1
`define ACL_US_DIV_LAST 6'h31
`define ACL_MS_DIV_LAST 10'h3e7
`endif

// ### hw/acl_rule_counter.v
// one rule's 11-bit alternative counter: timed count-down or packet count-up
`timescale 1ns/1ns
`include "acl_action_defines.vh"
module acl_rule_counter (
   input wire i_clk,          // core clock
   input wire i_rst_b,        // sync reset, active low
   input wire i_active,       // counter mode selected
   input wire i_count_up,     // 1 packet count-up, 0 timed count-down
   input wire i_unit_ms,      // 1 ms ticks, 0 us ticks
   input wire i_tick_us,      // one-cycle microsecond tick
   input wire i_tick_ms,      // one-cycle millisecond tick
   input wire i_pkt_hit,      // matched packet received on this port
   input wire [10:0] i_limit, // value from the action fields
   input wire i_clear,        // entry rewritten
   output reg o_expire        // one-cycle expiry pulse
);
   reg [10:0] cnt_q;
   reg [10:0] cnt_d;
   reg done_q;
   reg done_d;
   reg fire_d;
   wire tick;

   assign tick = i_unit_ms ? i_tick_ms : i_tick_us;

   // next state; a finished count stays put until the entry is rewritten or counter mode is left
   always @* begin
      cnt_d = cnt_q;
      done_d = done_q;
      fire_d = 1'b0;
      if (i_active && !done_q) begin
         if (i_count_up) begin
            if (cnt_q == i_limit) begin
               done_d = 1'b1;
               fire_d = 1'b1;
            end else if (i_pkt_hit) begin
               cnt_d = cnt_q + 11'h001;
            end
         end else begin
            if (cnt_q == 11'h000) begin
               done_d = 1'b1;
               fire_d = 1'b1;
            end else if (tick) begin
               cnt_d = cnt_q - 11'h001;
            end
         end
      end
      // a rewrite reloads the count, but an expiry in that same cycle keeps its pulse
      if (i_clear || !i_active) begin
         cnt_d = i_count_up ? 11'h000 : i_limit;
         done_d = 1'b0;
      end
   end

   // state registers
   always @(posedge i_clk) begin
      if (!i_rst_b) begin
         cnt_q <= 11'h000;
         done_q <= 1'b0;
         o_expire <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         done_q <= done_d;
         o_expire <= fire_d;
      end
   end
endmodule

// ### hw/acl_action_processing.v
// acl rule action processing for five ports: remark, map mode and counters
// ************************************************************
// ************************************************************
`timescale 1ns/1ns
`include "acl_action_defines.vh"
module acl_action_processing (
   input wire I_REF_CLK,                   // 50 MHz core clock
   input wire I_RST_B,                     // sync reset, active low
   input wire [7:0] I_REG_ADDR,            // direct register address
   input wire [7:0] I_REG_WDATA,           // write data
   input wire I_REG_WR,                    // write strobe
   input wire I_REG_RD,                    // read strobe
   output reg [7:0] O_REG_RDATA,           // read data, one cycle after strobe
   input wire [9:0] I_MATCH_MODE_FIELD,    // per-port match mode, 2 bits each
   input wire [9:0] I_MATCH_ENABLE_FIELD,  // per-port enable field, 2 bits each
   input wire I_PKT_VALID,                 // packet decision request
   input wire [2:0] I_PKT_PORT,            // ingress port 1..5
   input wire I_PKT_HIT,                   // rule matched this packet
   input wire [4:0] I_LUT_MAP,             // look-up table forwarding map
   output reg O_ACT_VALID,                 // decision valid pulse
   output reg [4:0] O_FWD_MAP,             // resulting forwarding map
   output reg O_REMARK,                    // replace vlan priority
   output reg [2:0] O_REMARK_PRIO,         // priority to write
   output wire [4:0] O_CNT_EXPIRE          // per-port counter interrupt pulse
);
   // ************************************************************
   // storage
   // ************************************************************
   reg [7:0] ind_ctrl_q;
   reg [7:0] ind_addr_q;
   reg [7:0] remark_byte_q [0:4];
   reg [7:0] forward_byte_q [0:4];
   reg [4:0] clear_q;
   reg [5:0] us_div_q;
   reg [9:0] ms_div_q;
   reg tick_us_q;
   reg tick_ms_q;
   wire sel_ok;
   wire [2:0] sel_idx;
   wire wr_data;
   wire [2:0] pkt_idx;
   wire [7:0] rd_byte;

   // port number 1..5 to array index; anything else is no port
   function [2:0] port_idx;
      input [3:0] port;
      begin
         port_idx = port[2:0] - 3'h1;
      end
   endfunction

   function port_ok;
      input [3:0] port;
      begin
         port_ok = (port >= 4'h1) && (port <= 4'h5);
      end
   endfunction

   // indirect select: only the acl table and a legal port reach the entry
   assign sel_ok = (ind_ctrl_q[7:5] == `ACL_TABLE_SEL) && port_ok(ind_ctrl_q[3:0]);
   assign sel_idx = port_idx(ind_ctrl_q[3:0]);
   assign wr_data = I_REG_WR && (I_REG_ADDR == `ACL_REG_IND_DATA) && sel_ok;
   assign pkt_idx = port_idx({1'b0, I_PKT_PORT});

   // ************************************************************
   // register port
   // ************************************************************
   // control and address registers, plus the clear pulse for entry writes through the data port
   always @(posedge I_REF_CLK) begin
      if (!I_RST_B) begin
         ind_ctrl_q <= 8'h00;
         ind_addr_q <= 8'h00;
         clear_q <= 5'h00;
      end else begin
         clear_q <= 5'h00;
         if (I_REG_WR && (I_REG_ADDR == `ACL_REG_IND_CTRL)) begin
            ind_ctrl_q <= I_REG_WDATA;
         end
         if (I_REG_WR && (I_REG_ADDR == `ACL_REG_IND_ADDR)) begin
            ind_addr_q <= I_REG_WDATA;
         end
         if (wr_data && ((ind_addr_q == `ACL_OFS_REMARK) ||
                         (ind_addr_q == `ACL_OFS_FORWARD))) begin
            clear_q[sel_idx] <= 1'b1;
         end
      end
   end

   // entry bytes; reset to zero, the port map included
   genvar p;
   generate
      for (p = 0; p < 5; p = p + 1) begin : g_entry
         always @(posedge I_REF_CLK) begin
            if (!I_RST_B) begin
               remark_byte_q[p] <= `ACL_RESET_BYTE;
               forward_byte_q[p] <= `ACL_RESET_BYTE;
            end else if (wr_data && (sel_idx == p)) begin
               if (ind_addr_q == `ACL_OFS_REMARK) begin
                  remark_byte_q[p] <= I_REG_WDATA;
               end
               if (ind_addr_q == `ACL_OFS_FORWARD) begin
                  forward_byte_q[p] <= I_REG_WDATA;
               end
            end
         end
      end
   endgenerate

   // selected entry byte; other offsets of the entry live elsewhere and read zero
   assign rd_byte = !sel_ok ? 8'h00 :
                    (ind_addr_q == `ACL_OFS_REMARK) ? remark_byte_q[sel_idx] :
                    (ind_addr_q == `ACL_OFS_FORWARD) ? forward_byte_q[sel_idx] : 8'h00;

   // registered read answer; unmapped addresses return zero
   always @(posedge I_REF_CLK) begin
      if (!I_RST_B) begin
         O_REG_RDATA <= 8'h00;
      end else if (I_REG_RD) begin
         case (I_REG_ADDR)
            `ACL_REG_IND_CTRL: O_REG_RDATA <= ind_ctrl_q;
            `ACL_REG_IND_ADDR: O_REG_RDATA <= ind_addr_q;
            `ACL_REG_IND_DATA: O_REG_RDATA <= rd_byte;
            default: O_REG_RDATA <= 8'h00;
         endcase
      end
   end

   // ************************************************************
   // time base
   // ************************************************************
   // shared prescaler; one tick per us and per ms for all five counters
   always @(posedge I_REF_CLK) begin
      if (!I_RST_B) begin
         us_div_q <= 6'h00;
         ms_div_q <= 10'h000;
         tick_us_q <= 1'b0;
         tick_ms_q <= 1'b0;
      end else begin
         tick_us_q <= 1'b0;
         tick_ms_q <= 1'b0;
         if (us_div_q == `ACL_US_DIV_LAST) begin
            us_div_q <= 6'h00;
            tick_us_q <= 1'b1;
            if (ms_div_q == `ACL_MS_DIV_LAST) begin
               ms_div_q <= 10'h000;
               tick_ms_q <= 1'b1;
            end else begin
               ms_div_q <= ms_div_q + 10'h001;
            end
         end else begin
            us_div_q <= us_div_q + 6'h01;
         end
      end
   end

   // ************************************************************
   // counters
   // ************************************************************
   wire [4:0] cnt_mode;
   generate
      for (p = 0; p < 5; p = p + 1) begin : g_cnt
         assign cnt_mode[p] = (I_MATCH_MODE_FIELD[2*p+1:2*p] == `ACL_MATCH_COUNT) &&
                              (I_MATCH_ENABLE_FIELD[2*p+1:2*p] == `ACL_ENABLE_COUNT);
         // limit is byte 0x0a followed by the top three bits of byte 0x0b
         acl_rule_counter u_cnt (
            .i_clk(I_REF_CLK),
            .i_rst_b(I_RST_B),
            .i_active(cnt_mode[p]),
            .i_count_up(forward_byte_q[p][`ACL_CMODE_BIT]),
            .i_unit_ms(forward_byte_q[p][`ACL_UNIT_BIT]),
            .i_tick_us(tick_us_q),
            .i_tick_ms(tick_ms_q),
            .i_pkt_hit(I_PKT_VALID && I_PKT_HIT && (pkt_idx == p)),
            .i_limit({remark_byte_q[p], forward_byte_q[p][7:5]}),
            .i_clear(clear_q[p]),
            .o_expire(O_CNT_EXPIRE[p])
         );
      end
   endgenerate

   // ************************************************************
   // packet action
   // ************************************************************
   wire [7:0] rb;
   wire [7:0] fb;
   wire pkt_ok;
   reg [4:0] map_d;
   assign pkt_ok = port_ok({1'b0, I_PKT_PORT});
   assign rb = pkt_ok ? remark_byte_q[pkt_idx] : 8'h00;
   assign fb = pkt_ok ? forward_byte_q[pkt_idx] : 8'h00;

   // map merge; bit n of the rule map is port n+1 as is the table map
   always @* begin
      map_d = I_LUT_MAP;
      if (I_PKT_HIT && pkt_ok && !cnt_mode[pkt_idx]) begin
         case (fb[6:5])
            `ACL_MAP_OR: map_d = I_LUT_MAP | fb[4:0];
            `ACL_MAP_AND: map_d = I_LUT_MAP & fb[4:0];
            `ACL_MAP_REPLACE: map_d = fb[4:0];
            default: map_d = I_LUT_MAP;
         endcase
      end
   end

   // decision registers; counter mode reuses the fields, so no remark then
   always @(posedge I_REF_CLK) begin
      if (!I_RST_B) begin
         O_ACT_VALID <= 1'b0;
         O_FWD_MAP <= 5'h00;
         O_REMARK <= 1'b0;
         O_REMARK_PRIO <= 3'h0;
      end else begin
         O_ACT_VALID <= I_PKT_VALID;
         if (I_PKT_VALID) begin
            O_FWD_MAP <= map_d;
            O_REMARK <= I_PKT_HIT && pkt_ok && !cnt_mode[pkt_idx] &&
                        rb[`ACL_REMARK_EN_BIT];
            O_REMARK_PRIO <= {1'b0, rb[1:0]};
         end
      end
   end
endmodule

// ### tb/acl_action_processing_chk.sv
// concurrent checks on the acl action-processing ports
`timescale 1ns/1ns
module acl_action_processing_chk (
   input wire I_REF_CLK, // clock
   input wire I_RST_B, // reset
   input wire [7:0] I_REG_ADDR, // address
   input wire I_REG_RD, // read
   input wire [7:0] O_REG_RDATA, // read data
   input wire I_PKT_VALID, // request
   input wire [2:0] I_PKT_PORT, // port
   input wire I_PKT_HIT, // hit
   input wire [4:0] I_LUT_MAP, // table map
   input wire O_ACT_VALID, // answer
   input wire [4:0] O_FWD_MAP, // map
   input wire O_REMARK, // remark
   input wire [2:0] O_REMARK_PRIO, // priority
   input wire [4:0] O_CNT_EXPIRE // expiry
);
   default clocking @(posedge I_REF_CLK); endclocking
   default disable iff (!I_RST_B);
   // decisions follow requests by exactly one cycle and hold otherwise
   AST_ACT: assert property (I_PKT_VALID |=> O_ACT_VALID) else $error("no decision");
   AST_NOV: assert property (!I_PKT_VALID |=> !O_ACT_VALID && $stable(O_FWD_MAP)
      && $stable(O_REMARK)) else $error("output moved without request");
   AST_MISS: assert property (I_PKT_VALID && !I_PKT_HIT |=>
      O_FWD_MAP == $past(I_LUT_MAP) && !O_REMARK) else $error("miss changed map");
   AST_BADP: assert property (I_PKT_VALID && (I_PKT_PORT == 3'h0 || I_PKT_PORT > 3'h5)
      |=> O_FWD_MAP == $past(I_LUT_MAP)) else $error("bad port changed map");
   // only two priority bits exist, so the top bit never shows
   AST_PRIO: assert property (O_REMARK |-> !O_REMARK_PRIO[2]) else $error("prio range");
   AST_EXP1: assert property (|O_CNT_EXPIRE |=>
      (O_CNT_EXPIRE & $past(O_CNT_EXPIRE)) == 5'h00) else $error("expiry not a pulse");
   AST_UNMAP: assert property (I_REG_RD && !(I_REG_ADDR inside {8'h6e, 8'h6f, 8'ha0})
      |=> O_REG_RDATA == 8'h00) else $error("unmapped read not zero");
   AST_RDH: assert property (!I_REG_RD |=> $stable(O_REG_RDATA)) else $error("rdata moved");
   COV_RMK: cover property (O_ACT_VALID && O_REMARK);
   COV_EXP: cover property (|O_CNT_EXPIRE);
   COV_RD: cover property (I_REG_RD ##1 O_REG_RDATA != 8'h00);
endmodule
bind acl_action_processing acl_action_processing_chk u_chk (.I_REF_CLK(I_REF_CLK),
   .I_RST_B(I_RST_B), .I_REG_ADDR(I_REG_ADDR), .I_REG_RD(I_REG_RD),
   .O_REG_RDATA(O_REG_RDATA), .I_PKT_VALID(I_PKT_VALID), .I_PKT_PORT(I_PKT_PORT),
   .I_PKT_HIT(I_PKT_HIT), .I_LUT_MAP(I_LUT_MAP), .O_ACT_VALID(O_ACT_VALID),
   .O_FWD_MAP(O_FWD_MAP), .O_REMARK(O_REMARK), .O_REMARK_PRIO(O_REMARK_PRIO),
   .O_CNT_EXPIRE(O_CNT_EXPIRE));

// ### tb/acl_action_processing_tb.sv
// self-checking bench for acl action processing
`timescale 1ns/1ns
module acl_action_processing_tb;
   reg clk = 1'b0;
   reg rst_b = 1'b0;
   reg [7:0] addr = 8'h00;
   reg [7:0] wdata = 8'h00;
   reg wr = 1'b0;
   reg rd = 1'b0;
   reg [9:0] match_mode = 10'h000;
   reg [9:0] match_en = 10'h3ff;
   reg pv = 1'b0;
   reg [2:0] port = 3'h0;
   reg hit = 1'b0;
   reg [4:0] lut = 5'h00;
   wire [7:0] rdata;
   wire av;
   wire [4:0] fwd;
   wire rmk;
   wire [2:0] prio;
   wire [4:0] xp;
   integer miscompares = 0;
   integer n_checks = 0;
   integer cyc = 0;
   integer i;
   integer k;
   integer mc;
   integer tx;
   reg [31:0] lfsr = 32'd77299;
   reg [7:0] ba [0:7];
   reg [7:0] bb [0:7];
   reg [7:0] r;
   reg ms_seen = 1'b0;
   always #10 clk = ~clk;
   acl_action_processing DUT (.I_REF_CLK(clk), .I_RST_B(rst_b), .I_REG_ADDR(addr),
      .I_REG_WDATA(wdata), .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata),
      .I_MATCH_MODE_FIELD(match_mode), .I_MATCH_ENABLE_FIELD(match_en), .I_PKT_VALID(pv),
      .I_PKT_PORT(port), .I_PKT_HIT(hit), .I_LUT_MAP(lut), .O_ACT_VALID(av),
      .O_FWD_MAP(fwd), .O_REMARK(rmk), .O_REMARK_PRIO(prio), .O_CNT_EXPIRE(xp));
   // a hung handshake must still reach the verdict
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         miscompares = miscompares + 1;
         results;
      end
   end
   // expiry pulses are looked at mid-cycle, where they have settled
   always @(negedge clk) begin
      if (xp[3] === 1'b1) ms_seen = 1'b1;
   end
   function [31:0] nxt(input [31:0] l);
      nxt = l[0] ? ((l >> 1) ^ 32'h80200003) : (l >> 1);
   endfunction
   task chk(input [7:0] seen, input [7:0] want, input [8*10-1:0] what);
      begin
         n_checks = n_checks + 1;
         if (seen !== want) begin
            miscompares = miscompares + 1;
            $display("[FAIL] %0s exp %h got %h", what, want, seen);
         end
      end
   endtask
   task wrr(input [7:0] a, input [7:0] d);
      begin
         @(posedge clk) #1;
         addr = a;
         wdata = d;
         wr = 1'b1;
         @(posedge clk) #1;
         wr = 1'b0;
      end
   endtask
   // read data lands one cycle after the strobe edge
   task rdr(input [7:0] a);
      begin
         @(posedge clk) #1;
         addr = a;
         rd = 1'b1;
         @(posedge clk) #1;
         rd = 1'b0;
         @(posedge clk) #1;
         r = rdata;
      end
   endtask
   task entry(input [2:0] p, input [7:0] a, input [7:0] b);
      begin
         ba[p] = a;
         bb[p] = b;
         wrr(8'h6e, {3'h2, 2'h0, p});
         wrr(8'h6f, 8'h0a);
         wrr(8'ha0, a);
         wrr(8'h6f, 8'h0b);
         wrr(8'ha0, b);
         rdr(8'ha0);
         chk(r, b, "byte0b");
      end
   endtask
   // model: counter mode or a miss passes the table map untouched
   task pkt(input [2:0] p, input h, input [4:0] l, input cm);
      reg [4:0] m;
      reg e;
      begin
         e = h && p >= 3'h1 && p <= 3'h5 && !cm;
         m = l;
         if (e) begin
            case (bb[p][6:5])
               2'h1: m = l | bb[p][4:0];
               2'h2: m = l & bb[p][4:0];
               2'h3: m = bb[p][4:0];
               default: m = l;
            endcase
         end
         @(posedge clk) #1;
         pv = 1'b1;
         port = p;
         hit = h;
         lut = l;
         @(posedge clk) #1;
         pv = 1'b0;
         chk({7'h00, av}, 8'h01, "valid");
         chk({3'h0, fwd}, {3'h0, m}, "map");
         chk({7'h00, rmk}, {7'h00, e & ba[p][2]}, "remark");
         if (e & ba[p][2]) chk({5'h00, prio}, {6'h00, ba[p][1:0]}, "prio");
      end
   endtask
   task wt(input integer b, input integer lim);
      begin
         k = 0;
         while (xp[b] !== 1'b1 && k < lim) begin
            @(posedge clk) #1;
            k = k + 1;
         end
      end
   endtask
   task results;
      begin
         $display("checks %0d miscompares %0d", n_checks, miscompares);
         if (miscompares == 0 && n_checks > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   initial begin
      for (i = 0; i < 8; i = i + 1) begin
         ba[i] = 8'h00;
         bb[i] = 8'h00;
      end
      repeat (5) @(posedge clk);
      #1 rst_b = 1'b1;
      chk({3'h0, fwd}, 8'h00, "rst_map");
      rdr(8'ha0);
      chk(r, 8'h00, "rst_byte");
      wrr(8'h6e, 8'h01);
      wrr(8'ha0, 8'h5a);
      rdr(8'ha0);
      chk(r, 8'h00, "bad_table");
      wrr(8'h55, 8'h5a);
      rdr(8'h55);
      chk(r, 8'h00, "unmapped");
      $display("register test done");
      // every map mode and every priority code once, then random traffic
      for (i = 0; i < 4; i = i + 1) begin
         entry(i[2:0] + 3'h1, 8'h07 ^ i[7:0], {1'b0, i[1:0], 5'h15});
         pkt(i[2:0] + 3'h1, 1'b1, 5'h0e, 1'b0);
      end
      for (i = 0; i < 30; i = i + 1) begin
         lfsr = nxt(lfsr);
         entry(lfsr[2:0] % 3'h5 + 3'h1, lfsr[15:8], lfsr[23:16]);
         lfsr = nxt(lfsr);
         pkt(lfsr[2:0], lfsr[3], lfsr[8:4], 1'b0);
      end
      $display("decision test done");
      entry(3'h2, 8'h00, 8'h48);
      entry(3'h3, 8'h00, 8'h60);
      entry(3'h4, 8'h00, 8'h30);
      match_mode = 10'h054;
      match_en = 10'h000;
      mc = cyc + 1;
      pkt(3'h2, 1'b1, 5'h1f, 1'b1);
      wt(1, 8);
      chk(k[7:0], 8'h08, "up_early");
      pkt(3'h2, 1'b1, 5'h1f, 1'b1);
      wt(1, 8);
      chk({7'h00, k < 8}, 8'h01, "up_fire");
      // rewriting the entry must rearm a counter that has already fired
      entry(3'h2, 8'h00, 8'h48);
      pkt(3'h2, 1'b1, 5'h1f, 1'b1);
      pkt(3'h2, 1'b1, 5'h1f, 1'b1);
      wt(1, 8);
      chk({7'h00, k < 8}, 8'h01, "clr_fire");
      // limit 3 in us: the shared prescaler ticks on bench cycles 56, 106, ...
      wt(2, 300);
      tx = mc + (56 - mc % 50) % 50 + 101 - mc;
      k = cyc - mc;
      chk(k[7:0], tx[7:0], "down_fire");
      chk({7'h00, ms_seen}, 8'h00, "ms_unit");
      $display("counter test done");
      results;
   end
endmodule
